// File: eeprom_regs.vh
// Constants for the two-wire serial memory target.
// Assumes a 25 MHz system clock; included by the serial memory target design.
`ifndef EEPROM_REGS_VH
`define EEPROM_REGS_VH

`define CLASS_PATTERN       4'ha
`define ERASED_BYTE         8'hff
`define MEM_BYTES           4096
`define PAGE_BYTES          32
`define CLK_HZ              25000000
// Program cycle time in microseconds, power-up delay in microseconds
`define PROGRAM_TIME_US     5000
`define POWERUP_DELAY_US    1000
`define PROGRAM_CYCLES      ((`PROGRAM_TIME_US * (`CLK_HZ / 1000)) / 1000)
`define POWERUP_CYCLES      ((`POWERUP_DELAY_US * (`CLK_HZ / 1000)) / 1000)
`define FIFO_WIDTH          8
`define FIFO_DEPTH          16

`endif

// File: byte_fifo.v
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   // Clock and reset
   input  wire             clk,
   input  wire             srst,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = store[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            store[wr_ptr] <= in_data;
            wr_ptr        <= wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end

endmodule

`default_nettype wire

// File: serial_eeprom.v
// Two-wire serial bus target for a 4096-byte memory with 32-byte pages.
// Assumes scl/sda/pins are asynchronous; clk is much faster than scl.
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_regs.vh"

module serial_eeprom #(
   parameter PROGRAM_CYCLES = `PROGRAM_CYCLES,
   parameter POWERUP_CYCLES = `POWERUP_CYCLES
)
(
   // Clock and reset
   input  wire       clk,
   input  wire       srst,
   // Bus pins
   input  wire       scl,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe,
   // Straps
   input  wire       select_pin_0,
   input  wire       select_pin_1,
   input  wire       select_pin_2,
   input  wire       write_inhibit,
   // Status
   output reg        busy,
   output reg        ready
);

   localparam [6:0] ST_IDLE = 7'b0000001;
   localparam [6:0] ST_DEV  = 7'b0000010;
   localparam [6:0] ST_AHI  = 7'b0000100;
   localparam [6:0] ST_ALO  = 7'b0001000;
   localparam [6:0] ST_WDAT = 7'b0010000;
   localparam [6:0] ST_RDAT = 7'b0100000;
   localparam [6:0] ST_RACK = 7'b1000000;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg [1:0] scl_s;
   reg [1:0] sda_s;
   reg [1:0] sel0_s;
   reg [1:0] sel1_s;
   reg [1:0] sel2_s;
   reg [1:0] wi_s;
   reg       scl_d;
   reg       sda_d;

   always @(posedge clk)
   begin
      scl_s  <= {scl_s[0], scl};
      sda_s  <= {sda_s[0], sda_in};
      sel0_s <= {sel0_s[0], select_pin_0};
      sel1_s <= {sel1_s[0], select_pin_1};
      sel2_s <= {sel2_s[0], select_pin_2};
      wi_s   <= {wi_s[0], write_inhibit};
      scl_d  <= scl_s[1];
      sda_d  <= sda_s[1];
   end

   wire scl_rise = scl_s[1] & ~scl_d;
   wire scl_fall = ~scl_s[1] & scl_d;
   wire start_ev = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   wire stop_ev  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

   ////////////////////////////////////////////////////////////////////
   // Storage
   reg [7:0]  mem [0:`MEM_BYTES-1];
   reg [7:0]  page [0:`PAGE_BYTES-1];
   reg [31:0] page_dirty;
   reg [6:0]  page_no;
   reg [4:0]  offset;
   reg [11:0] addr;
   reg [3:0]  ahi;

   ////////////////////////////////////////////////////////////////////
   // Bus state
   reg [6:0]  state;
   reg [3:0]  bitc;
   reg [7:0]  shreg;
   reg        ack_phase;
   reg        drive_low;
   reg        write_seen;
   reg        inhibit_hit;
   reg        first_data;
   reg [22:0] timer;
   reg [5:0]  commit_idx;
   reg        committing;
   reg        rd_load;

   assign sda_oe  = drive_low;
   assign sda_out = 1'b0;

   wire [7:0] rx_byte = {shreg[6:0], sda_s[1]};
   wire       addr_ok = (rx_byte[7:4] == `CLASS_PATTERN)
                        && (rx_byte[3:1] == {sel2_s[1], sel1_s[1], sel0_s[1]});

   ////////////////////////////////////////////////////////////////////
   // Read-data prefetch FIFO: commit traffic stalls it via valid
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [7:0] fifo_out;
   reg        fifo_pop;
   wire       fifo_push = rd_load & fifo_in_ready & ~committing;

   byte_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (4)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst | start_ev),
      .in_valid  (rd_load & ~committing),
      .in_ready  (fifo_in_ready),
      .in_data   (mem[addr]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out)
   );

   integer i;
   initial
   begin
      for (i = 0; i < `MEM_BYTES; i = i + 1)
         mem[i] = `ERASED_BYTE;
   end

   // Commit one byte per clock; page wins over read prefetch
   always @(posedge clk)
   begin
      if (committing && page_dirty[commit_idx[4:0]])
         mem[{page_no, commit_idx[4:0]}] <= page[commit_idx[4:0]];
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         state       <= ST_IDLE;
         bitc        <= 4'h0;
         shreg       <= 8'h00;
         ack_phase   <= 1'b0;
         drive_low   <= 1'b0;
         write_seen  <= 1'b0;
         inhibit_hit <= 1'b0;
         first_data  <= 1'b0;
         busy        <= 1'b0;
         ready       <= 1'b0;
         timer       <= 23'h0;
         committing  <= 1'b0;
         commit_idx  <= 6'h00;
         page_dirty  <= 32'h0000_0000;
         page_no     <= 7'h00;
         offset      <= 5'h00;
         addr        <= 12'h000;
         ahi         <= 4'h0;
         rd_load     <= 1'b0;
         fifo_pop    <= 1'b0;
      end
      else
      begin
         fifo_pop <= 1'b0;
         // Power-up delay, then program cycle timing
         if (!ready)
         begin
            if (timer == POWERUP_CYCLES[22:0] - 23'h1)
            begin
               ready <= 1'b1;
               timer <= 23'h0;
            end
            else
               timer <= timer + 23'h1;
         end
         else if (busy)
         begin
            if (committing)
            begin
               commit_idx <= commit_idx + 6'h01;
               if (commit_idx == 6'd31)
                  committing <= 1'b0;
            end
            if (timer == PROGRAM_CYCLES[22:0] - 23'h1)
            begin
               busy       <= 1'b0;
               timer      <= 23'h0;
               page_dirty <= 32'h0000_0000;
            end
            else
               timer <= timer + 23'h1;
         end
         // Keep the FIFO topped up with successive bytes
         rd_load <= (state == ST_RDAT || state == ST_RACK) && fifo_in_ready;
         if (fifo_push)
            addr <= addr + 12'h001;

         if (!ready)
            state <= ST_IDLE;
         else if (stop_ev)
         begin
            drive_low <= 1'b0;
            state     <= ST_IDLE;
            if (write_seen && !inhibit_hit && !busy)
            begin
               busy       <= 1'b1;
               committing <= 1'b1;
               commit_idx <= 6'h00;
               timer      <= 23'h0;
            end
            write_seen <= 1'b0;
         end
         else if (start_ev)
         begin
            drive_low <= 1'b0;
            state     <= ST_DEV;
            bitc      <= 4'h0;
            ack_phase <= 1'b0;
         end
         else if (scl_rise && !ack_phase && state != ST_IDLE
                  && state != ST_RDAT && state != ST_RACK)
         begin
            shreg <= rx_byte;
            bitc  <= bitc + 4'h1;
            if (bitc == 4'h7)
            begin
               bitc      <= 4'h0;
               ack_phase <= 1'b1;
               case (state)
                  ST_DEV:
                  begin
                     if (!addr_ok || busy)
                     begin
                        state     <= ST_IDLE;
                        ack_phase <= 1'b0;
                     end
                     else if (rx_byte[0])
                        state <= ST_RDAT;
                     else
                        state <= ST_AHI;
                  end
                  ST_AHI:
                  begin
                     ahi   <= rx_byte[3:0];
                     state <= ST_ALO;
                  end
                  ST_ALO:
                  begin
                     addr        <= {ahi, rx_byte};
                     page_no     <= {ahi, rx_byte[7:5]};
                     offset      <= rx_byte[4:0];
                     first_data  <= 1'b1;
                     inhibit_hit <= 1'b0;
                     state       <= ST_WDAT;
                  end
                  ST_WDAT:
                  begin
                     first_data <= 1'b0;
                     if (!inhibit_hit)
                     begin
                        page[offset]       <= rx_byte;
                        page_dirty[offset] <= 1'b1;
                        offset             <= offset + 5'h01;
                        write_seen         <= 1'b1;
                     end
                     else
                     begin
                        state     <= ST_IDLE;
                        ack_phase <= 1'b0;
                     end
                  end
                  default:
                     state <= ST_IDLE;
               endcase
            end
         end
         else if (scl_fall)
         begin
            // Inhibit strobed on the fall before the first data bit
            if (ack_phase && state == ST_WDAT && first_data)
            begin
               inhibit_hit <= wi_s[1];
               if (wi_s[1])
                  write_seen <= 1'b0;
            end
            if (ack_phase && state != ST_RDAT && state != ST_RACK)
            begin
               // Drive ack low over the ninth clock
               if (!drive_low && !(state == ST_WDAT && inhibit_hit))
                  drive_low <= 1'b1;
               else
               begin
                  drive_low <= 1'b0;
                  ack_phase <= 1'b0;
               end
            end
            else if (state == ST_RDAT)
            begin
               // Ack cycle after device address, then data bits
               if (ack_phase && !drive_low)
                  drive_low <= 1'b1;
               else
               begin
                  ack_phase <= 1'b0;
                  if (bitc == 4'h0)
                  begin
                     shreg    <= fifo_out;
                     fifo_pop <= fifo_out_valid;
                     drive_low <= ~fifo_out[7];
                     bitc     <= 4'h1;
                  end
                  else if (bitc == 4'h8)
                  begin
                     drive_low <= 1'b0;
                     state     <= ST_RACK;
                     bitc      <= 4'h0;
                  end
                  else
                  begin
                     drive_low <= ~shreg[7 - bitc[2:0]];
                     bitc      <= bitc + 4'h1;
                  end
               end
            end
         end
         else if (scl_rise && state == ST_RACK)
         begin
            // Master ack continues, no-ack waits for stop
            state <= sda_s[1] ? ST_IDLE : ST_RDAT;
         end
      end
   end

endmodule

`default_nettype wire

// File: serial_eeprom_checker.sv
// Port-level checks for the serial memory target.
// Bound to serial_eeprom; assumes scl phases of at least four clocks.
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_checker #(
   parameter int PROGRAM_CYCLES = 200,
   parameter int POWERUP_CYCLES = 20
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Straps and status
   input wire logic select_pin_0,
   input wire logic select_pin_1,
   input wire logic select_pin_2,
   input wire logic write_inhibit,
   input wire logic busy,
   input wire logic ready
);
   logic [31:0] busy_len;
   logic [31:0] wait_len;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   // Counters, since a long repetition would unroll far too much
   always @(posedge clk)
   begin
      busy_len <= (srst || !busy) ? 32'h0000_0000 : busy_len + 32'h0000_0001;
      wait_len <= srst ? 32'h0000_0000 : wait_len + 32'(!ready);
   end
   ////////////////////////////////////////////////////////////////////////////
   a_drive_low: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
   a_reset_quiet: assert property ($fell(srst) |-> !(sda_oe | busy | ready))
      else $error("output active after reset");
   a_high_steady: assert property (scl && $past(scl) |-> $stable(sda_oe))
      else $error("sda moved while scl high");
   a_drive_in_low: assert property ($rose(sda_oe) |-> !scl)
      else $error("sda pulled while scl high");
   a_busy_mute: assert property (busy |-> !sda_oe) else $error("ack while busy");
   a_busy_at_stop: assert property ($rose(busy) |-> scl && sda_in)
      else $error("program cycle without stop");
   a_busy_span: assert property ($fell(busy) |-> busy_len <= PROGRAM_CYCLES
      && busy_len >= PROGRAM_CYCLES / 2) else $error("program cycle length wrong");
   a_ready_time: assert property (wait_len <= POWERUP_CYCLES + 3 || ready)
      else $error("ready too late");
   a_ready_sticky: assert property (ready |=> ready) else $error("ready dropped");
   a_mute_unready: assert property (!ready |-> !sda_oe) else $error("ack before ready");
endmodule
bind serial_eeprom serial_eeprom_checker #(
   .PROGRAM_CYCLES(PROGRAM_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES)
) chk (
   .clk(clk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .select_pin_0(select_pin_0), .select_pin_1(select_pin_1), .select_pin_2(select_pin_2),
   .write_inhibit(write_inhibit), .busy(busy), .ready(ready)
);
`default_nettype wire

// File: bus_master.sv
// Behavioural two-wire bus master: start, stop and nine-bit transfers.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module bus_master (
   // Clock
   input  wire logic clk,
   // Bus lines
   output var  logic scl,
   output var  logic sda_low,
   input  wire logic sda
);
   // Idle bus: clock parked high, data released
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Also a repeated start; data moves one clock after scl falls
   task automatic start;
      gap(1);
      sda_low = 1'b0;
      gap(3);
      scl = 1'b1;
      gap(4);
      sda_low = 1'b1;
      gap(4);
      scl = 1'b0;
   endtask
   task automatic stop;
      gap(1);
      sda_low = 1'b1;
      gap(3);
      scl = 1'b1;
      gap(4);
      sda_low = 1'b0;
      gap(8);
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         gap(1);
         sda_low = ~tx[i];
         gap(3);
         scl = 1'b1;
         gap(2);
         rx[i] = sda;
         gap(2);
         scl = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// File: test_serial_eeprom.sv
// Self-checking bench for the two-wire serial memory target.
// Bus driven by bus_master; port checks are bound in separately.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module test_serial_eeprom;
   localparam int PROG = 200;
   localparam int PWR = 20;
   localparam logic [2:0] SEL = 3'h5;
   logic       clk = 1'b0;
   logic       srst;
   logic       write_inhibit;
   logic [2:0] sel;
   logic       scl;
   logic       sda_low;
   wire logic  sda_out;
   wire logic  sda_oe;
   wire logic  busy;
   wire logic  ready;
   wire logic  sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
   int         err_count;
   int         checked;
   always #20 clk = ~clk;
   serial_eeprom #(.PROGRAM_CYCLES(PROG), .POWERUP_CYCLES(PWR)) DUT (
      .clk(clk), .srst(srst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .select_pin_0(sel[0]), .select_pin_1(sel[1]), .select_pin_2(sel[2]),
      .write_inhibit(write_inhibit), .busy(busy), .ready(ready));
   bus_master m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
      return {4'ha, s, rw};
   endfunction
   task automatic send(input logic [7:0] d, output logic ack);
      logic [8:0] rx;
      m.xfer({d, 1'b1}, rx);
      ack = ~rx[0];
   endtask
   task automatic recv(input logic last, output logic [7:0] d);
      logic [8:0] rx;
      m.xfer({8'hff, last}, rx);
      d = rx[8:1];
   endtask
   task automatic addr_phase(input logic [15:0] a, output logic ok);
      logic k0, k1, k2;
      m.start();
      send(dev(SEL, 1'b0), k0);
      send(a[15:8], k1);
      send(a[7:0], k2);
      ok = k0 & k1 & k2;
   endtask
   task automatic sel_read(input logic [15:0] a);
      logic ok, k;
      addr_phase(a, ok);
      m.start();
      send(dev(SEL, 1'b1), k);
      `CHK(ok & k, 1'b1)
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic ok, k;
      addr_phase(a, ok);
      send(d, k);
      m.stop();
      `CHK(ok & k, 1'b1)
      `CHK(busy, 1'b1)
   endtask
   task automatic wait_idle;
      for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
      `CHK(busy, 1'b0)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic s_address;
      logic k;
      send(dev(SEL, 1'b0), k);
      `CHK(k, 1'b0)
      m.stop();
      for (int s = 0; s < 8; s++)
      begin
         m.start();
         send(dev(s[2:0], 1'b0), k);
         `CHK(k, s[2:0] == SEL)
         if (s[2:0] != SEL) send(8'h00, k);
         if (s[2:0] != SEL) `CHK(k, 1'b0)
         m.stop();
      end
   endtask
   task automatic s_poll;
      logic k, ok;
      logic [7:0] d;
      int tries = 0;
      wr(16'hf456, 8'h5a);
      for (k = 1'b0; !k && tries < 12; tries++)
      begin
         m.start();
         send(dev(SEL, 1'b0), k);
         if (!k) m.stop();
      end
      `CHK(tries > 1, 1'b1)
      `CHK(k, 1'b1)
      m.stop();
      sel_read(16'h0456);
      recv(1'b1, d);
      m.stop();
      `CHK(d, 8'h5a)
      addr_phase(16'h0456, ok);
      m.stop();
      m.start();
      send(dev(SEL, 1'b1), k);
      recv(1'b1, d);
      m.stop();
      `CHK(d, 8'h5a)
   endtask
   task automatic s_page;
      logic k, all;
      logic [7:0] d;
      addr_phase(16'h003e, all);
      for (int i = 0; i < 34; i++)
      begin
         send(8'h40 + i[7:0], k);
         all &= k;
      end
      m.stop();
      `CHK(all, 1'b1)
      wait_idle();
      sel_read(16'h0020);
      for (int i = 0; i < 33; i++)
      begin
         recv(i == 32, d);
         `CHK(d, i == 32 ? 8'hff : 8'h42 + i[7:0])
      end
      m.stop();
   endtask
   task automatic s_wrap;
      logic [7:0] d;
      wr(16'h0fff, 8'hc3);
      wait_idle();
      sel_read(16'h0fff);
      recv(1'b0, d);
      `CHK(d, 8'hc3)
      recv(1'b1, d);
      `CHK(d, 8'hff)
      m.stop();
   endtask
   task automatic s_inhibit;
      logic ok, k;
      logic [7:0] d;
      write_inhibit = 1'b1;
      addr_phase(16'h0100, ok);
      send(8'h77, k);
      m.stop();
      `CHK({ok, k}, 2'h2)
      `CHK(busy, 1'b0)
      write_inhibit = 1'b0;
      sel_read(16'h0100);
      recv(1'b1, d);
      m.stop();
      `CHK(d, 8'hff)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Full run takes roughly 10000 clocks
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      err_count = 0;
      checked = 0;
      srst = 1'b1;
      write_inhibit = 1'b0;
      sel = SEL;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      `CHK(ready, 1'b0)
      repeat (PWR + 4) @(negedge clk);
      `CHK(ready, 1'b1)
      s_address();
      s_poll();
      s_page();
      s_wrap();
      s_inhibit();
      tally_and_finish();
   end
endmodule
`default_nettype wire
